// file: hw/pts_ctl.sv
// control, status and timing logic of the trigger sequencer
`timescale 1ns/1ps
module pts_ctl (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        device_idle,
    input  wire logic        oscillator_clock,
    input  wire logic        converter_conversion_clock,
    input  wire logic        timer1_clock,
    input  wire logic        timer2_clock,
    input  wire logic        timer3_clock,
    input  wire logic [3:0]  wait_input,
    output logic      [3:0]  trigger_output,
    output logic      [1:0]  input_wait_mode,
    output logic             single_step_mode,
    output logic             irq
);
    logic [15:0] cst_q;
    pts_pkg::pts_con_t con_q;
    logic [15:0] lim_q;
    pts_pkg::pts_cmd_word_t cmd_q;
    logic        cmd_valid_q;
    logic [2:0]  stat_q;
    logic [2:0]  ien_q;
    logic        wdto_q;
    // two-flop synchronisers for the foreign clock sources and wait inputs
    logic [8:0]  sync1_q;
    logic [8:0]  sync2_q;
    logic [8:0]  prev_q;
    logic        src_edge;
    logic [4:0]  div_cnt_q;
    logic        mod_tick;
    logic        active;
    logic        running;
    pts_pkg::pts_state_t state_q;
    logic [3:0]  pw_cnt_q [pts_pkg::PTS_NOUT];
    logic [3:0]  trig_q;
    logic [9:0]  wdt_cnt_q;
    logic [9:0]  wdt_limit;
    logic [15:0] delay_cnt_q;
    logic        wr;
    logic        rd;
    logic        swt_pulse;
    logic        emit_now;
    logic        clr_wr;
    logic [2:0]  ev;
    logic        wait_met;
    logic        wdt_expire;

    assign wr = psel & penable & pwrite & clk_en;
    assign rd = psel & ~penable & ~pwrite;
    assign clr_wr = wr && (paddr == pts_pkg::PTS_CLR_OFS);

    // bus answers in the access cycle while clk_en is high, no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready  <= psel & ~penable;
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cst_q <= pts_pkg::PTS_CST_RST;
        end else if (wr && paddr == pts_pkg::PTS_CST_OFS) begin
            cst_q <= pwdata[15:0] & pts_pkg::PTS_CST_WMASK;
        end else if (clk_en) begin
            cst_q[pts_pkg::PTS_SWT_BIT] <= 1'b0; // self-clearing, zero write is harmless
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            con_q <= pts_pkg::PTS_CON_RST;
        end else if (wr && paddr == pts_pkg::PTS_CON_OFS) begin
            con_q <= pwdata[15:0] & pts_pkg::PTS_CON_WMASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lim_q <= 16'h0000;
            ien_q <= 3'h0;
        end else if (wr) begin
            if (paddr == pts_pkg::PTS_LIM_OFS) begin
                lim_q <= pwdata[15:0];
            end
            if (paddr == pts_pkg::PTS_IEN_OFS) begin
                ien_q <= pwdata[2:0];
            end
        end
    end

    assign swt_pulse = wr && paddr == pts_pkg::PTS_CST_OFS && pwdata[pts_pkg::PTS_SWT_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (clk_en && rd) begin
            case (paddr)
                pts_pkg::PTS_CST_OFS: prdata <= {16'h0000, cst_q[15:7], wdto_q, 4'h0, cst_q[1:0]};
                pts_pkg::PTS_CON_OFS: prdata <= {16'h0000, con_q};
                pts_pkg::PTS_STAT_OFS: prdata <= {29'h0, stat_q};
                pts_pkg::PTS_IEN_OFS: prdata <= {29'h0, ien_q};
                // live count or stored limit
                pts_pkg::PTS_LIM_OFS: prdata <= cst_q[pts_pkg::PTS_IVIS_BIT] ? {16'h0000, delay_cnt_q}
                                                                            : {16'h0000, lim_q};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 9'h000;
            sync2_q <= 9'h000;
            prev_q  <= 9'h000;
        end else if (clk_en) begin
            sync1_q <= {wait_input, timer3_clock, timer2_clock, timer1_clock,
                        converter_conversion_clock, oscillator_clock};
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // source selection; peripheral clock is pclk itself
    always_comb begin
        case (con_q.src)
            pts_pkg::PTS_SRC_PERIPH: src_edge = 1'b1;
            pts_pkg::PTS_SRC_OSC:    src_edge = sync2_q[0] & ~prev_q[0];
            pts_pkg::PTS_SRC_CONV:   src_edge = sync2_q[1] & ~prev_q[1];
            pts_pkg::PTS_SRC_TMR1:   src_edge = sync2_q[2] & ~prev_q[2];
            pts_pkg::PTS_SRC_TMR2:   src_edge = sync2_q[3] & ~prev_q[3];
            pts_pkg::PTS_SRC_TMR3:   src_edge = sync2_q[4] & ~prev_q[4];
            default:                 src_edge = 1'b0; // reserved codes stop the clock
        endcase
    end

    assign active  = cst_q[pts_pkg::PTS_EN_BIT]
                   & ~(cst_q[pts_pkg::PTS_SIDL_BIT] & device_idle);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt_q <= 5'h00;
        end else if (clk_en) begin
            if (!active) begin
                div_cnt_q <= 5'h00;
            end else if (src_edge) begin
                div_cnt_q <= (div_cnt_q >= con_q.div) ? 5'h00 : div_cnt_q + 5'h01;
            end
        end
    end
    assign mod_tick = clk_en & active & src_edge & (div_cnt_q >= con_q.div);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_q       <= '0;
            cmd_valid_q <= 1'b0;
        end else if (wr && paddr == pts_pkg::PTS_CMD_OFS) begin
            cmd_q       <= pwdata[3:0];
            cmd_valid_q <= 1'b1;
        end else if (mod_tick && cmd_valid_q && state_q != pts_pkg::PTS_ST_WAIT) begin
            cmd_valid_q <= (state_q == pts_pkg::PTS_ST_IDLE);
        end else if (mod_tick && state_q == pts_pkg::PTS_ST_WAIT && wait_met) begin
            cmd_valid_q <= 1'b0;
        end
    end

    assign running = cst_q[pts_pkg::PTS_STRT_BIT];

    // wait level selection: mode bit 0 inverts sense, the only user of the field
    always_comb begin
        case (cmd_q.op)
            pts_pkg::PTS_CMD_WHI: wait_met = sync2_q[5 + cmd_q.sel] ^ input_wait_mode[0];
            pts_pkg::PTS_CMD_WLO: wait_met = ~sync2_q[5 + cmd_q.sel] ^ input_wait_mode[0];
            default:              wait_met = 1'b1;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= pts_pkg::PTS_ST_IDLE;
        end else if (clk_en && (!active || !running)) begin
            state_q <= pts_pkg::PTS_ST_IDLE;
        end else if (mod_tick) begin
            case (state_q)
                pts_pkg::PTS_ST_IDLE: state_q <= pts_pkg::PTS_ST_RUN;
                pts_pkg::PTS_ST_RUN: begin
                    if (cmd_valid_q && (cmd_q.op == pts_pkg::PTS_CMD_WHI || cmd_q.op == pts_pkg::PTS_CMD_WLO)) begin
                        state_q <= pts_pkg::PTS_ST_WAIT;
                    end else if (cmd_valid_q && cst_q[pts_pkg::PTS_SSEN_BIT]) begin
                        state_q <= pts_pkg::PTS_ST_STEP;
                    end
                end
                pts_pkg::PTS_ST_WAIT: if (wait_met) state_q <= pts_pkg::PTS_ST_RUN;
                pts_pkg::PTS_ST_STEP: if (swt_pulse) state_q <= pts_pkg::PTS_ST_RUN;
                default: state_q <= pts_pkg::PTS_ST_IDLE;
            endcase
        end
    end

    // an emit runs on a module tick, or via software trigger of a step command
    assign emit_now = (mod_tick && state_q == pts_pkg::PTS_ST_RUN && cmd_valid_q
                       && cmd_q.op == pts_pkg::PTS_CMD_EMIT)
                    || (swt_pulse && active && cmd_valid_q && cmd_q.op == pts_pkg::PTS_CMD_STEP);

    generate
        for (genvar i = 0; i < pts_pkg::PTS_NOUT; i++) begin : g_out
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pw_cnt_q[i] <= 4'h0;
                    trig_q[i]   <= 1'b0;
                end else if (clk_en && !active) begin
                    pw_cnt_q[i] <= 4'h0;
                    trig_q[i]   <= 1'b0;
                end else if (emit_now && cmd_q.sel == 2'(i)) begin
                    if (cst_q[pts_pkg::PTS_TOGL_BIT]) begin
                        trig_q[i] <= ~trig_q[i];
                    end else begin
                        trig_q[i]   <= 1'b1;
                        pw_cnt_q[i] <= con_q.pwd;
                    end
                end else if (mod_tick && !cst_q[pts_pkg::PTS_TOGL_BIT] && trig_q[i]) begin
                    if (pw_cnt_q[i] == 4'h0) begin
                        trig_q[i] <= 1'b0;
                    end else begin
                        pw_cnt_q[i] <= pw_cnt_q[i] - 4'h1;
                    end
                end
            end
        end
    endgenerate

    assign wdt_limit = (con_q.wdt == 3'b000) ? 10'h000
                     : 10'(pts_pkg::PTS_WDT_BASE << con_q.wdt);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_cnt_q <= 10'h000;
        end else if (clk_en && (!active || state_q != pts_pkg::PTS_ST_WAIT)) begin
            wdt_cnt_q <= 10'h000; // restart per command
        end else if (wdt_expire) begin
            wdt_cnt_q <= 10'h000;
        end else if (mod_tick && con_q.wdt != 3'b000) begin
            wdt_cnt_q <= wdt_cnt_q + 10'h001;
        end
    end

    assign wdt_expire = mod_tick && state_q == pts_pkg::PTS_ST_WAIT && con_q.wdt != 3'b000
                      && wdt_cnt_q + 10'h001 >= wdt_limit;

    // clearing via control write only; a same-cycle expiry wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdto_q <= 1'b0;
        end else if (wdt_expire) begin
            wdto_q <= 1'b1;
        end else if (wr && paddr == pts_pkg::PTS_CST_OFS && !pwdata[pts_pkg::PTS_WDTO_BIT]) begin
            wdto_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            delay_cnt_q <= 16'h0000;
        end else if (clk_en && (!active || state_q == pts_pkg::PTS_ST_IDLE)) begin
            delay_cnt_q <= 16'h0000;
        end else if (mod_tick) begin
            delay_cnt_q <= (delay_cnt_q == lim_q) ? 16'h0000 : delay_cnt_q + 16'h0001;
        end
    end

    assign ev = {swt_pulse, emit_now, wdt_expire};

    // set wins over a same-cycle clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_q <= 3'h0;
        end else begin
            stat_q <= (stat_q & ~(clr_wr ? pwdata[2:0] : 3'h0)) | ev;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq              <= 1'b0;
            trigger_output   <= 4'h0;
            input_wait_mode  <= 2'b00;
            single_step_mode <= 1'b0;
        end else if (clk_en) begin
            irq              <= |(stat_q & ien_q);
            trigger_output   <= trig_q;
            input_wait_mode  <= cst_q[1:0];
            single_step_mode <= cst_q[pts_pkg::PTS_SSEN_BIT];
        end
    end
endmodule

// file: hw/pts_pkg.sv
// package for the peripheral trigger sequencer control block
package pts_pkg;
    localparam logic [11:0] PTS_CST_OFS  = 12'h000;
    localparam logic [11:0] PTS_CON_OFS  = 12'h004;
    localparam logic [11:0] PTS_STAT_OFS = 12'h008;
    localparam logic [11:0] PTS_CLR_OFS  = 12'h00c;
    localparam logic [11:0] PTS_IEN_OFS  = 12'h010;
    localparam logic [11:0] PTS_LIM_OFS  = 12'h014;
    localparam logic [11:0] PTS_CMD_OFS  = 12'h018;
    localparam logic [15:0] PTS_CST_RST  = 16'h0000;
    localparam logic [15:0] PTS_CON_RST  = 16'h0000;
    localparam logic [15:0] PTS_CST_WMASK = 16'hb783;
    localparam logic [15:0] PTS_CON_WMASK = 16'hfff7;
    localparam int PTS_EN_BIT    = 15;
    localparam int PTS_SIDL_BIT  = 13;
    localparam int PTS_TOGL_BIT  = 12;
    localparam int PTS_SWT_BIT   = 10;
    localparam int PTS_SSEN_BIT  = 9;
    localparam int PTS_IVIS_BIT  = 8;
    localparam int PTS_STRT_BIT  = 7;
    localparam int PTS_WDTO_BIT  = 6;
    localparam int PTS_NOUT      = 4;
    localparam logic [9:0] PTS_WDT_BASE = 10'h004;
    // status bits: 0 watchdog timeout, 1 trigger emitted, 2 software trigger
    localparam int PTS_NEV = 3;
    typedef enum logic [2:0] {
        PTS_SRC_PERIPH = 3'b000,
        PTS_SRC_OSC    = 3'b001,
        PTS_SRC_CONV   = 3'b010,
        PTS_SRC_TMR1   = 3'b011,
        PTS_SRC_TMR2   = 3'b100,
        PTS_SRC_TMR3   = 3'b101
    } pts_src_t;
    typedef enum logic [1:0] {
        PTS_ST_IDLE = 2'b00,
        PTS_ST_RUN  = 2'b01,
        PTS_ST_WAIT = 2'b10,
        PTS_ST_STEP = 2'b11
    } pts_state_t;
    typedef enum logic [1:0] {
        PTS_CMD_EMIT  = 2'b00,
        PTS_CMD_WHI   = 2'b01,
        PTS_CMD_WLO   = 2'b10,
        PTS_CMD_STEP  = 2'b11
    } pts_cmd_t;
    typedef struct packed {
        logic     [2:0] src;
        logic     [4:0] div;
        logic     [3:0] pwd;
        logic           rsvd;
        logic     [2:0] wdt;
    } pts_con_t;
    typedef struct packed {
        pts_cmd_t       op;
        logic     [1:0] sel;
    } pts_cmd_word_t;
endpackage

// file: tb/pts_ctl_properties.sv
// port assertions of the trigger sequencer control block
`timescale 1ns/1ps
module pts_ctl_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        clk_en,
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        single_step_mode,
    input wire logic [1:0]  input_wait_mode,
    input wire logic        irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc    = psel && penable && pready;
    wire rd_acc = acc && !pwrite;
    wire cst_wr = acc && pwrite && clk_en && paddr == pts_pkg::PTS_CST_OFS;
    pready_setup_a: assert property (psel && !penable && clk_en |=> pready)
        else $error("no answer one cycle after setup");
    pready_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside an access cycle");
    no_slverr_a: assert property (psel |-> !pslverr)
        else $error("error response seen");
    upper_zero_a: assert property (rd_acc |-> prdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    cst_reserved_a: assert property (rd_acc && paddr == pts_pkg::PTS_CST_OFS |-> (prdata[15:0] & 16'h483c) == 0)
        else $error("unimplemented control bits read one");
    con_reserved_a: assert property (rd_acc && paddr == pts_pkg::PTS_CON_OFS |-> !prdata[3])
        else $error("unimplemented config bit reads one");
    step_follow_a: assert property (cst_wr |=> ##1 single_step_mode == $past(pwdata[9], 2))
        else $error("single-step output does not follow write");
    wait_mode_a: assert property (cst_wr |=> ##1 input_wait_mode == $past(pwdata[1:0], 2))
        else $error("input wait mode does not follow write");
    irq_mask_a: assert property (acc && pwrite && clk_en && paddr == pts_pkg::PTS_IEN_OFS
        && pwdata[2:0] == 3'h0 |=> ##1 !irq)
        else $error("interrupt stays up with all sources masked");
endmodule

// file: tb/pts_periph_model.sv
// peripheral side: counts trigger pulses and measures their width in bus clocks
`timescale 1ns/1ps
module pts_periph_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [3:0] trig,
    output int              rises [4],
    output int              width [4]
);
    int         run [4];
    logic [3:0] last_q;
    // width is only known once the line falls; a toggled line gets its width when it is toggled low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_q <= 4'h0;
            for (int i = 0; i < 4; i++) begin
                rises[i] <= 0;
                width[i] <= 0;
                run[i]   <= 0;
            end
        end else begin
            last_q <= trig;
            for (int i = 0; i < 4; i++) begin
                run[i] <= trig[i] ? run[i] + 1 : 0;
                if (trig[i] && !last_q[i]) rises[i] <= rises[i] + 1;
                if (!trig[i] && last_q[i]) width[i] <= run[i];
            end
        end
    end
endmodule

// file: tb/pts_ctl_tb_top.sv
// self-checking testbench of the trigger sequencer control block
`timescale 1ns/1ps
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin fail_count++; \
    $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module pts_ctl_tb_top;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, device_idle = 0, clk_en = 1;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rdat;
    logic        pready, pslverr, single_step_mode, irq;
    logic [3:0]  wait_input = 4'hf, trigger_output;
    logic [1:0]  input_wait_mode;
    logic [5:0]  slow_q = 0;
    int          fail_count = 0, check_count = 0, cyc = 0, rises [4], width [4];
    pts_ctl i_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .device_idle(device_idle), .oscillator_clock(slow_q[1]),
        .converter_conversion_clock(slow_q[2]), .timer1_clock(slow_q[3]), .timer2_clock(slow_q[4]),
        .timer3_clock(slow_q[5]), .wait_input(wait_input), .trigger_output(trigger_output),
        .input_wait_mode(input_wait_mode), .single_step_mode(single_step_mode), .irq(irq));
    pts_periph_model i_periph (.pclk(pclk), .presetn(presetn), .trig(trigger_output),
        .rises(rises), .width(width));
    initial forever #5 pclk = ~pclk;
    // distinct source periods (4 to 64 bus clocks) so a swapped source select shows up
    always @(posedge pclk) slow_q <= slow_q + 6'h01;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            fail_count++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdat = prdata;
        {psel, penable} <= 2'b00;
    endtask
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        apb(1'b1, a, {16'h0000, d});
    endtask
    task automatic rd(input string n, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(n, e, rdat)
    endtask
    task automatic emit(input logic [1:0] s);
        wr(pts_pkg::PTS_CMD_OFS, {12'h000, pts_pkg::PTS_CMD_EMIT, s});
    endtask
    task automatic pulse(input logic [15:0] cfg, input logic [1:0] s, input int w, input int frz);
        int r0, n;
        n = 0;
        wr(pts_pkg::PTS_CON_OFS, cfg);
        r0 = rises[s];
        emit(s);
        // freeze the block mid-pulse: the line must simply stand longer
        if (frz > 0) begin
            while (trigger_output[s] !== 1'b1) @(negedge pclk);
            @(posedge pclk);
            clk_en <= 1'b0;
            repeat (frz) @(posedge pclk);
            clk_en <= 1'b1;
        end
        while ((rises[s] != r0 + 1 || trigger_output[s] !== 1'b0) && n < 900) begin
            @(negedge pclk);
            n++;
        end
        @(negedge pclk);
        `CHK("rises", r0 + 1, rises[s])
        `CHK("width", w, width[s])
    endtask
    task automatic no_pulse(input logic [1:0] s);
        int r0;
        r0 = rises[s];
        emit(s);
        repeat (60) @(negedge pclk);
        `CHK("quiet", r0, rises[s])
    endtask
    task automatic wdog(input logic [2:0] code);
        int n;
        n = 0;
        wr(pts_pkg::PTS_CST_OFS, 16'h8080);
        wr(pts_pkg::PTS_CLR_OFS, 16'h0007);
        wr(pts_pkg::PTS_CON_OFS, {13'h0000, code});
        wait_input <= 4'h0;
        wr(pts_pkg::PTS_CMD_OFS, {12'h000, pts_pkg::PTS_CMD_WHI, 2'b00});
        while (irq !== 1'b1 && n < 1200) begin
            @(negedge pclk);
            n++;
        end
        `CHK("wdog_time", code != 0, n + 3 >= (4 << code) && n <= (4 << code) + 10)
        rd("cst_wdto", pts_pkg::PTS_CST_OFS, {16'h0000, 8'h80, 1'b1, code != 0, 6'h00});
        wait_input <= 4'hf;
    endtask
    // step command waits for the software trigger while the sequencer is stopped
    task automatic step_trig();
        int r0;
        r0 = rises[2];
        wr(pts_pkg::PTS_CST_OFS, 16'h8000);
        wr(pts_pkg::PTS_CMD_OFS, {12'h000, pts_pkg::PTS_CMD_STEP, 2'b10});
        repeat (6) @(negedge pclk);
        `CHK("step_hold", r0, rises[2])
        wr(pts_pkg::PTS_CST_OFS, 16'h8400);
        repeat (6) @(negedge pclk);
        `CHK("step_trig", r0 + 1, rises[2])
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd("cst_rst", pts_pkg::PTS_CST_OFS, 32'h0);
        rd("con_rst", pts_pkg::PTS_CON_OFS, 32'h0);
        wr(pts_pkg::PTS_CON_OFS, 16'hffff);
        rd("con_mask", pts_pkg::PTS_CON_OFS, 32'hfff7);
        wr(pts_pkg::PTS_CST_OFS, 16'h483c);
        rd("cst_mask", pts_pkg::PTS_CST_OFS, 32'h0);
        rd("unmapped", 12'h01c, 32'h0);
        wr(pts_pkg::PTS_LIM_OFS, 16'h0012);
        rd("limit", pts_pkg::PTS_LIM_OFS, 32'h12);
        wr(pts_pkg::PTS_CST_OFS, 16'h0100);
        rd("live", pts_pkg::PTS_LIM_OFS, 32'h0);
        wr(pts_pkg::PTS_CST_OFS, 16'h8080);
        pulse(16'h0000, 2'd0, 1, 0);
        pulse(16'h00f0, 2'd1, 16, 0);
        pulse(16'h00f0, 2'd1, 56, 40);
        pulse(16'h0110, 2'd2, 4, 0);
        for (int k = 1; k < 6; k++) pulse({k[2:0], 13'h0}, 2'd3, 2 << k, 0);
        wr(pts_pkg::PTS_CON_OFS, 16'h0000);
        wr(pts_pkg::PTS_CST_OFS, 16'h9080);
        for (int k = 0; k < 2; k++) begin
            emit(2'd1);
            repeat (8) @(negedge pclk);
            `CHK("toggle", k == 0, trigger_output[1])
        end
        wr(pts_pkg::PTS_CST_OFS, 16'h0080);
        no_pulse(2'd0);
        device_idle <= 1'b1;
        wr(pts_pkg::PTS_CST_OFS, 16'ha080);
        no_pulse(2'd0);
        device_idle <= 1'b0;
        wr(pts_pkg::PTS_CST_OFS, 16'h8080);
        // the emit held back while disabled fires now; let it land before clearing
        repeat (4) @(negedge pclk);
        wr(pts_pkg::PTS_CLR_OFS, 16'h0007);
        rd("swt_zero", pts_pkg::PTS_STAT_OFS, 32'h0);
        wr(pts_pkg::PTS_CST_OFS, 16'h8480);
        rd("swt_one", pts_pkg::PTS_STAT_OFS, 32'h4);
        wr(pts_pkg::PTS_CST_OFS, 16'h8283);
        repeat (2) @(negedge pclk);
        `CHK("step", 1'b1, single_step_mode)
        `CHK("itm", 2'h3, input_wait_mode)
        step_trig();
        wr(pts_pkg::PTS_IEN_OFS, 16'h0001);
        wdog(3'd0);
        wdog(3'd3);
        wdog(3'd1);
        rd("status", pts_pkg::PTS_STAT_OFS, 32'h1);
        wr(pts_pkg::PTS_IEN_OFS, 16'h0000);
        repeat (2) @(negedge pclk);
        `CHK("irq_mask", 1'b0, irq)
        wr(pts_pkg::PTS_IEN_OFS, 16'h0001);
        repeat (2) @(negedge pclk);
        `CHK("irq_on", 1'b1, irq)
        wr(pts_pkg::PTS_CLR_OFS, 16'h0001);
        repeat (2) @(negedge pclk);
        `CHK("irq_clr", 1'b0, irq)
        close_out();
    end
endmodule
bind pts_ctl pts_ctl_properties i_chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .single_step_mode(single_step_mode), .input_wait_mode(input_wait_mode), .irq(irq));
